/* rtl/sir_cfg.svh */
// constants of the interrupt response unit
// assumes inclusion by bare name from package and design files
`ifndef SIR_CFG_SVH
`define SIR_CFG_SVH

`define SIR_ADDR_W        12
`define SIR_VECTOR_DEF    12'h3ff
`define SIR_PROG_DEPTH    13'h1000
`define SIR_INSTR_CYCLES  2
`define SIR_PHASE_FIRST   1'b0
`define SIR_PHASE_LAST    1'b1
`define SIR_ADDR_RST      12'h000
`define SIR_LAT_MIN       3
`define SIR_LAT_MAX       4

`endif

/* rtl/sir_pkg.sv */
// types shared by the interrupt response unit
// assumes sir_cfg.svh on the include path
`include "sir_cfg.svh"

package sir_pkg;

	typedef logic [`SIR_ADDR_W-1:0] sir_addr_t;

	// operating state kept across a service routine
	typedef struct packed {
		logic bank;
		logic carry;
		logic zero;
	} sir_flags_s;

	typedef enum logic [1:0] {
		SIR_RUN     = 2'b01,
		SIR_SERVICE = 2'b10
	} sir_state_e;

endpackage : sir_pkg

/* rtl/sir_irq_resp.sv */
// interrupt response unit of a small 8-bit soft core
// assumes the core decodes instructions and feeds its next address, flags and controls on mclk
// Notes on behaviour
// RULE1: a request seen high abandons the running sequence, saves state, enters service routine
// RULE2: after the service routine, resume at the left point with saved state restored
// RULE3: only one interrupt handled at a time; no nesting
// RULE4: every instruction, service routine included, takes exactly two clock cycles
// RULE5: entry acts as a call to the vector, pushing the return point
// RULE6: vector defaults to 3FF hex, last word of a 1K program memory
// RULE7: a design-time parameter may set the vector anywhere in program memory
// RULE8: exactly two interrupt ports: active-high request in, acknowledge out
// RULE9: response starts within 3 or 4 cycles of a qualifying high request
// RULE10: request sampled once per instruction, level on other cycles ignored
// RULE11: requester should hold request high longer than one cycle
// RULE12: accept only when enabled, awake and not already in service
// RULE13: save zero, carry and bank on entry; restore all on service return
// RULE14: the abandoned fetched instruction runs first after the service return
// RULE15: requester keeps request high until the acknowledge pulse
`timescale 1ns/1ps
`default_nettype none
`include "sir_cfg.svh"

module sir_irq_resp #(
	parameter sir_pkg::sir_addr_t VECTOR = `SIR_VECTOR_DEF
) (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                clk_en,
	input  wire logic                internal_reset,
	input  wire logic                irq,
	output var  logic                irq_ack,
	input  wire logic                sleep,
	input  wire sir_pkg::sir_addr_t  core_next_addr,
	input  wire sir_pkg::sir_flags_s core_flags,
	input  wire logic                ie_set,
	input  wire logic                ie_clr,
	input  wire logic                ret_svc,
	input  wire logic                ret_enable,
	output var  sir_pkg::sir_addr_t  fetch_addr,
	output var  logic                push_stb,
	output var  sir_pkg::sir_addr_t  push_addr,
	output var  logic                restore_stb,
	output var  sir_pkg::sir_flags_s restored_flags,
	output var  logic                int_enabled,
	output var  logic                in_service,
	output var  logic                sleeping
);

	sir_pkg::sir_state_e state;
	sir_pkg::sir_state_e next_state;
	sir_pkg::sir_flags_s saved_flags;
	logic                phase;
	logic                step;
	logic                boundary;
	logic                take;
	logic                leave;

	// vector must lie inside program memory
	AST_VECTOR_IN_RANGE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
		{1'b0, VECTOR} < `SIR_PROG_DEPTH)
		else $error("vector outside program memory");

	assign step     = clk_en && !internal_reset && !sleeping;
	// instruction change edge: the only edge that looks at the request
	assign boundary = step && (phase == `SIR_PHASE_LAST); // [RULE4] [RULE10]
	assign take     = boundary && irq && int_enabled && !sleep && (state == sir_pkg::SIR_RUN); // [RULE12] [RULE3]
	assign leave    = boundary && ret_svc && (state == sir_pkg::SIR_SERVICE);

	// two-cycle instruction phase
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			phase <= `SIR_PHASE_FIRST;
		else if (clk_en && internal_reset)
			phase <= `SIR_PHASE_FIRST;
		else if (step)
			phase <= ~phase; // [RULE4]
	end

	// sleep entered only at an instruction change, left on any edge
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			sleeping <= 1'b0;
		else if (clk_en)
		begin
			if (internal_reset)
				sleeping <= 1'b0;
			else if (sleeping)
				sleeping <= sleep;
			else if (boundary && !take)
				sleeping <= sleep;
		end
	end

	always_comb
	begin
		next_state = state;
		case (state)
			sir_pkg::SIR_RUN:
			begin
				if (take)
					next_state = sir_pkg::SIR_SERVICE; // [RULE1]
			end
			sir_pkg::SIR_SERVICE:
			begin
				if (leave)
					next_state = sir_pkg::SIR_RUN; // [RULE2]
			end
			default:
				next_state = sir_pkg::SIR_RUN;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			state <= sir_pkg::SIR_RUN;
		else if (clk_en && internal_reset)
			state <= sir_pkg::SIR_RUN;
		else if (clk_en)
			state <= next_state;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			in_service <= 1'b0;
		else if (clk_en && internal_reset)
			in_service <= 1'b0;
		else if (clk_en)
			in_service <= (next_state == sir_pkg::SIR_SERVICE);
	end

	// program enable; cleared on entry, set again or left off by the return
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			int_enabled <= 1'b0;
		else if (clk_en)
		begin
			if (internal_reset || take)
				int_enabled <= 1'b0; // [RULE3]
			else if (leave)
				int_enabled <= ret_enable;
			else if (boundary && ie_set)
				int_enabled <= 1'b1;
			else if (boundary && ie_clr)
				int_enabled <= 1'b0;
		end
	end

	// fetch address: vector replaces the next instruction on entry
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			fetch_addr <= `SIR_ADDR_RST;
		else if (clk_en && internal_reset)
			fetch_addr <= `SIR_ADDR_RST;
		else if (take)
			fetch_addr <= VECTOR; // [RULE6] [RULE7] [RULE1]
		else if (boundary)
			fetch_addr <= core_next_addr;
	end

	// call push of the abandoned instruction's own address
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			push_stb  <= 1'b0;
			push_addr <= `SIR_ADDR_RST;
		end
		else if (clk_en)
		begin
			push_stb <= take; // [RULE5]
			if (take)
				push_addr <= fetch_addr; // [RULE14]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_ack <= 1'b0;
		else if (clk_en)
			irq_ack <= take; // [RULE8] [RULE9]
	end

	// operating state saved on entry, handed back on return
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			saved_flags <= '0;
		else if (take)
			saved_flags <= core_flags; // [RULE13]
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			restore_stb    <= 1'b0;
			restored_flags <= '0;
		end
		else if (clk_en)
		begin
			restore_stb <= leave; // [RULE2]
			if (leave)
				restored_flags <= saved_flags; // [RULE13]
		end
	end

	AST_ACK_ONLY_AT_BOUNDARY: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE10]
		(clk_en && !irq_ack) ##1 (clk_en && irq_ack) |-> $past(phase) == `SIR_PHASE_LAST && $past(irq))
		else $error("acknowledge not tied to a sampled request");

	AST_NO_NEST: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
		(clk_en && in_service && !ret_svc) |=> !(clk_en && $rose(irq_ack)) || !$past(in_service))
		else $error("second interrupt taken during service");

	AST_VECTOR_ON_ACK: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
		(clk_en && $rose(irq_ack)) |-> fetch_addr == VECTOR && push_stb && in_service)
		else $error("entry did not go to the vector");

	AST_PUSH_ABANDONED: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE14]
		(take) |=> push_addr == $past(fetch_addr))
		else $error("return point is not the abandoned address");

	AST_FLAGS_SAVED: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
		(leave) |=> restore_stb && restored_flags == $past(saved_flags))
		else $error("flags not restored on return");

	AST_PHASE_ALTERNATES: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
		(step && !$past(internal_reset)) |=> phase != $past(phase))
		else $error("instruction did not take two cycles");

	AST_ENABLE_GATES: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
		(boundary && irq && (!int_enabled || sleep)) |=> !irq_ack)
		else $error("request accepted while disabled or asleep");

	// a request missed on its first edge is taken on the next one
	AST_LATENCY: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9]
		($rose(irq) && step && int_enabled && !in_service && !sleep && !ie_clr)
		##1 (step && irq && !sleep && !irq_ack) |=> irq_ack)
		else $error("response slower than four cycles");

	AST_EXIT_SERVICE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
		(leave) |=> !in_service && fetch_addr == $past(core_next_addr))
		else $error("return did not resume the program");

	// pulse widths and pairing of the entry and return strobes
	AST_ACK_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
		(clk_en && irq_ack) |=> !irq_ack)
		else $error("acknowledge longer than one cycle");

	AST_PUSH_WITH_ACK: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
		irq_ack == push_stb)
		else $error("call push not paired with acknowledge");

	AST_RESTORE_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
		(clk_en && restore_stb) |=> !restore_stb)
		else $error("restore strobe longer than one cycle");

	// flag capture, entry enable clear, service state, fetch following and enable set
	AST_FLAGS_CAPTURED: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
		(take) |=> saved_flags == $past(core_flags))
		else $error("flags not saved on entry");

	AST_ENTRY_CLEARS_ENABLE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
		(take) |=> !int_enabled && in_service)
		else $error("entry left interrupts enabled");

	AST_STATE_MIRROR: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
		in_service == (state == sir_pkg::SIR_SERVICE))
		else $error("service flag disagrees with state");

	AST_FETCH_FOLLOWS: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
		(boundary && !take) |=> fetch_addr == $past(core_next_addr))
		else $error("fetch address did not follow the core");

	AST_ENABLE_ON_SET: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
		(boundary && ie_set && !take && !leave) |=> int_enabled)
		else $error("enable instruction had no effect");

	// sleep, core reset and clock enable
	AST_SLEEP_NO_ACK: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
		(sleeping) |=> !irq_ack)
		else $error("request accepted while asleep");

	AST_SLEEP_AT_BOUNDARY: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
		$rose(sleeping) |-> $past(boundary))
		else $error("sleep entered inside an instruction");

	AST_IRESET_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
		(clk_en && internal_reset) |=> !in_service && !int_enabled && !sleeping && fetch_addr == `SIR_ADDR_RST)
		else $error("core reset left state behind");

	AST_FREEZE_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
		(!clk_en) |=> $stable(fetch_addr) && $stable(phase) && $stable(in_service))
		else $error("state moved while clock enable low");

endmodule : sir_irq_resp
`default_nettype wire

/* verification/sir_req_model.sv */
// closed-loop requester standing in for the user system logic
// assumes it shares mclk and rst_n with the response unit
`timescale 1ns/1ps
`default_nettype none
module sir_req_model (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic want,
	input  wire logic irq_ack,
	output var  logic irq
);
	// drop on acknowledge, else follow the wish to interrupt
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else if (irq_ack)
			irq <= 1'b0;
		else
			irq <= want;
	end
endmodule : sir_req_model
`default_nettype wire

/* verification/sir_irq_resp_tb_top.sv */
// self-checking bench of the interrupt response unit
// assumes the core side is modelled by plain bench levels
`timescale 1ns/1ps
`default_nettype none
module sir_irq_resp_tb_top;
	logic                mclk = 1'b0, rst_n = 1'b0, want = 1'b0, irq, irq_ack, sleep = 1'b0;
	logic                ie_set = 1'b0, ie_clr = 1'b0, ret_svc = 1'b0, ret_enable = 1'b0;
	logic                clk_en = 1'b1, internal_reset = 1'b0;
	logic                push_stb, restore_stb, int_enabled, in_service, sleeping;
	sir_pkg::sir_addr_t  core_next_addr = 12'h123, fetch_addr, push_addr;
	sir_pkg::sir_flags_s core_flags = 3'h5, restored_flags;
	int                  error_cnt = 0, comparisons = 0, cycles = 0, n;
	always #4 mclk = ~mclk;
	sir_irq_resp u_sir_irq_resp (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .internal_reset(internal_reset),
		.irq(irq), .irq_ack(irq_ack), .sleep(sleep), .core_next_addr(core_next_addr),
		.core_flags(core_flags), .ie_set(ie_set), .ie_clr(ie_clr), .ret_svc(ret_svc),
		.ret_enable(ret_enable), .fetch_addr(fetch_addr), .push_stb(push_stb), .push_addr(push_addr),
		.restore_stb(restore_stb), .restored_flags(restored_flags), .int_enabled(int_enabled),
		.in_service(in_service), .sleeping(sleeping));
	sir_req_model u_sir_req_model (.mclk(mclk), .rst_n(rst_n), .want(want), .irq_ack(irq_ack), .irq(irq));
	task chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t bit got %b exp %b", $time, got, exp);
		end
	endtask : chk_bit
	task chk_val(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t value got %h exp %h", $time, got, exp);
		end
	endtask : chk_val
	task complete_run;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	task pulse(input logic set_not_clr);
		@(posedge mclk);
		if (set_not_clr)
			ie_set <= 1'b1;
		else
			ie_clr <= 1'b1;
		repeat (2) @(posedge mclk);
		ie_set <= 1'b0;
		ie_clr <= 1'b0;
		#1;
	endtask : pulse
	// request, measure response, then ask for more while in service
	task t_entry;
		pulse(1'b1);
		chk_bit(int_enabled, 1'b1);
		@(posedge mclk) want <= 1'b1;
		for (n = 0; n < 8 && irq_ack !== 1'b1; n++)
			@(posedge mclk) #1;
		chk_bit(n >= 2 && n <= 3, 1'b1);
		chk_val(fetch_addr, 12'h3ff);
		chk_bit(push_stb, 1'b1);
		chk_val(push_addr, 12'h123);
		chk_bit(in_service, 1'b1);
		@(posedge mclk) core_flags <= 3'h2;
		#1 chk_bit(irq_ack | push_stb, 1'b0);
		for (n = 0; n < 8; n++)
			@(posedge mclk) #1 chk_bit(irq_ack, 1'b0);
		@(posedge mclk) want <= 1'b0;
	endtask : t_entry
	task t_return(input logic [11:0] exp_flags);
		@(posedge mclk) ret_enable <= 1'b1;
		ret_svc <= 1'b1;
		for (n = 0; n < 4 && restore_stb !== 1'b1; n++)
		begin
			@(posedge mclk) if (n == 1) ret_svc <= 1'b0;
			#1;
		end
		chk_val(12'(restored_flags), exp_flags);
		chk_bit(in_service, 1'b0);
		chk_bit(int_enabled, 1'b1);
		chk_val(fetch_addr, 12'h123);
		@(posedge mclk) ret_svc <= 1'b0;
	endtask : t_return
	task t_disabled;
		pulse(1'b0);
		chk_bit(int_enabled, 1'b0);
		@(posedge mclk) want <= 1'b1;
		for (n = 0; n < 6; n++)
			@(posedge mclk) #1 chk_bit(irq_ack, 1'b0);
		@(posedge mclk) want <= 1'b0;
	endtask : t_disabled
	// held request refused while asleep, taken after wake-up
	task t_sleep;
		pulse(1'b1);
		@(posedge mclk) sleep <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk_bit(sleeping, 1'b1);
		@(posedge mclk) want <= 1'b1;
		for (n = 0; n < 6; n++)
			@(posedge mclk) #1 chk_bit(irq_ack, 1'b0);
		@(posedge mclk) sleep <= 1'b0;
		for (n = 0; n < 8 && irq_ack !== 1'b1; n++)
			@(posedge mclk) #1;
		chk_bit(n < 8, 1'b1);
		chk_bit(in_service, 1'b1);
		chk_val(push_addr, 12'h123);
		@(posedge mclk) want <= 1'b0;
	endtask : t_sleep
	// core reset in service, then a clock-enable freeze
	task t_ireset_freeze;
		@(posedge mclk) internal_reset <= 1'b1;
		@(posedge mclk) internal_reset <= 1'b0;
		#1 chk_bit(in_service | int_enabled | sleeping, 1'b0);
		chk_val(fetch_addr, 12'h000);
		@(posedge mclk) clk_en <= 1'b0;
		core_next_addr <= 12'h456;
		repeat (4) @(posedge mclk);
		#1 chk_val(fetch_addr, 12'h000);
		@(posedge mclk) clk_en <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk_val(fetch_addr, 12'h456);
	endtask : t_ireset_freeze
	initial
	begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk_val(fetch_addr, 12'h000);
		chk_bit(irq_ack | in_service | int_enabled, 1'b0);
		t_entry();
		t_return(12'h5);
		t_disabled();
		t_sleep();
		t_ireset_freeze();
		complete_run();
	end
endmodule : sir_irq_resp_tb_top
`default_nettype wire
